/* File: hw/fsi_irq_unit.sv */
// Interrupt unit of the fingerprint sensor: control, status and threshold registers
//
// Operation
// - Source 0 is finger detect, source 1 is the external interrupt pin.
// - Disabled source never asserts interrupt pin nor requests an endpoint 2 packet.
// - Disabled but unmasked source still sets its pending bit.
// - Masked source cannot set its pending bit.
// - Writing mask bits leaves already set pending bits unchanged.
// - External edge mode with default polarity sets pending on falling pin edge.
// - Control bit 7: external polarity, 0 falling or low, 1 rising or high.
// - Control bit 6: finger polarity, 0 falling or low, 1 rising or high.
// - Control bit 5: external source edge when 0, level when 1.
// - Control bit 4: finger source edge when 0, level when 1.
// - Control bits 3 and 2 mask external and finger sources.
// - Control bits 1 and 0 enable external and finger sources.
// - Writing 1 to a pending bit clears it.
// - After reset status bits 7 to 4 and pending bits 1 and 0 read zero.
// - Status bits 3 and 2 show live pin and finger levels always.
// - Live finger bit stays low without finger, may toggle with finger.
// - Status bit 1 external pending, bit 0 finger pending.
// - Status bits 7 to 4 read zero; writes there are ignored.
// - Threshold bits 6:4 voltage level, bits 3:0 sharing capacitor size.
// - Finger events only while automatic finger detection is enabled if bit 6 is 1; at 0, detection off forces the active low level.
`timescale 1ns/1ps
`default_nettype none
module fsi_irq_unit
  import fsi_pkg::*;
(
  input  wire logic                  core_clk,
  input  wire logic                  nrst,
  // Register port
  input  wire logic [ADDR_W-1:0]     reg_addr,
  input  wire logic                  reg_wr,
  input  wire logic                  reg_rd,
  input  wire logic [DATA_W-1:0]     reg_wdata,
  output logic      [DATA_W-1:0]     reg_rdata,
  // Request sources
  input  wire logic                  ext_irq_pin,
  input  wire logic                  finger_detect_raw,
  input  wire logic                  auto_finger_detect_enable,
  // Notification
  output logic                       irq_out_pin,
  output logic                       usb_ep2_req,
  // Finger detect tuning
  output logic      [THR_VOLT_W-1:0] detect_voltage_level,
  output logic      [THR_CAP_W-1:0]  sharing_cap_size
);
  // Register state
  logic [DATA_W-1:0]  ctrl_q;
  logic [DATA_W-1:0]  ctrl_d;
  logic [DATA_W-1:0]  thr_q;
  logic [DATA_W-1:0]  thr_d;
  logic [NUM_SRC-1:0] pending_bits_q;
  logic [NUM_SRC-1:0] pending_bits_d;
  logic [DATA_W-1:0]  rdata_q;
  logic [DATA_W-1:0]  rdata_d;
  logic               irq_q;
  logic               irq_d;
  logic               ep2_q;
  logic               ep2_d;

  // Decoded control fields
  logic [NUM_SRC-1:0] source_polarity_bits;
  logic [NUM_SRC-1:0] trigger_type_bits;
  logic [NUM_SRC-1:0] source_mask_bits;
  logic [NUM_SRC-1:0] source_enable_bits;

  // Source levels and events
  logic [NUM_SRC-1:0] raw_levels;
  logic [NUM_SRC-1:0] live_state_bits;
  logic [NUM_SRC-1:0] src_level;
  logic [NUM_SRC-1:0] src_event;
  logic [NUM_SRC-1:0] pend_set;
  logic [NUM_SRC-1:0] pend_clr;
  logic               wr_ctrl;
  logic               wr_status;
  logic               wr_thr;

  // Field split below assumes exactly two sources; refuse others at elaboration
  if (NUM_SRC != 2) begin : g_bad_src
    $error("fsi_irq_unit: exactly two sources are supported");
  end

  // Control register field split
  assign source_polarity_bits = ctrl_q[CTL_POL_LSB +: NUM_SRC];
  assign trigger_type_bits    = ctrl_q[CTL_TRIG_LSB +: NUM_SRC];
  assign source_mask_bits     = ctrl_q[CTL_MASK_LSB +: NUM_SRC];
  assign source_enable_bits   = ctrl_q[CTL_EN_LSB +: NUM_SRC];

  // Both sources arrive from outside the clock domain
  assign raw_levels[SRC_FINGER] = finger_detect_raw;
  assign raw_levels[SRC_EXT]    = ext_irq_pin;

  fsi_sync #(
    .WIDTH (NUM_SRC)
  ) u_sync (
    .core_clk (core_clk),
    .nrst     (nrst),
    .async_in (raw_levels),
    .sync_out (live_state_bits)
  );

  // Auto detection off forces the finger level low; requests stop only for finger polarity 1
  always_comb begin
    src_level             = live_state_bits;
    src_level[SRC_FINGER] = live_state_bits[SRC_FINGER] & auto_finger_detect_enable;
  end

  // One detector per source; polarity and trigger type per control bits
  for (genvar gi = 0; gi < NUM_SRC; gi++) begin : g_src
    fsi_src_detect u_det (
      .core_clk   (core_clk),
      .nrst       (nrst),
      .level_in   (src_level[gi]),
      .polarity   (source_polarity_bits[gi]),
      .trig_level (trigger_type_bits[gi]),
      .event_out  (src_event[gi])
    );
  end

  // Register write decode
  always_comb begin
    wr_ctrl   = 1'b0;
    wr_status = 1'b0;
    wr_thr    = 1'b0;
    if (reg_wr && reg_addr == OFS_IRQ_CONTROL) begin
      wr_ctrl = 1'b1;
    end else if (reg_wr && reg_addr == OFS_IRQ_STATUS) begin
      wr_status = 1'b1;
    end else if (reg_wr && reg_addr == OFS_FINGER_THRESHOLD) begin
      wr_thr = 1'b1;
    end
  end

  // Pending bits: mask blocks the set, enable does not; set beats clear
  always_comb begin
    pend_set = src_event & ~source_mask_bits;
    pend_clr = wr_status ? reg_wdata[STS_PEND_LSB +: NUM_SRC] : '0;
    // Control writes never touch the pending bits
    pending_bits_d = (pending_bits_q & ~pend_clr) | pend_set;
  end

  // Configuration registers
  always_comb begin
    ctrl_d = ctrl_q;
    thr_d  = thr_q;
    if (wr_ctrl) begin
      ctrl_d = reg_wdata;
    end
    if (wr_thr) begin
      thr_d = reg_wdata;
    end
  end

  // Notification: pin follows enabled pending; endpoint request on new enabled pending
  always_comb begin
    irq_d = |(pending_bits_d & source_enable_bits);
    ep2_d = |(pending_bits_d & ~pending_bits_q & source_enable_bits);
  end

  // Read data, registered one cycle after the read strobe
  always_comb begin
    rdata_d = rdata_q;
    if (reg_rd) begin
      if (reg_addr == OFS_IRQ_CONTROL) begin
        rdata_d = ctrl_q;
      end else if (reg_addr == OFS_IRQ_STATUS) begin
        // Upper nibble reads zero; live bits ignore all control settings
        rdata_d = '0;
        rdata_d[STS_LIVE_LSB +: NUM_SRC] = live_state_bits;
        rdata_d[STS_PEND_LSB +: NUM_SRC] = pending_bits_q;
      end else if (reg_addr == OFS_FINGER_THRESHOLD) begin
        rdata_d = thr_q;
      end else begin
        rdata_d = UNMAPPED_RDATA;
      end
    end
  end

  // State registers
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      ctrl_q         <= RST_IRQ_CONTROL;
      thr_q          <= RST_FINGER_THRESHOLD;
      pending_bits_q <= RST_PENDING;
      rdata_q        <= RST_RDATA;
      irq_q          <= 1'b0;
      ep2_q          <= 1'b0;
    end else begin
      ctrl_q         <= ctrl_d;
      thr_q          <= thr_d;
      pending_bits_q <= pending_bits_d;
      rdata_q        <= rdata_d;
      irq_q          <= irq_d;
      ep2_q          <= ep2_d;
    end
  end

  // Outputs straight from flip-flops
  assign reg_rdata            = rdata_q;
  assign irq_out_pin          = irq_q;
  assign usb_ep2_req          = ep2_q;
  assign detect_voltage_level = thr_q[THR_VOLT_LSB +: THR_VOLT_W];
  assign sharing_cap_size     = thr_q[THR_CAP_LSB +: THR_CAP_W];
endmodule : fsi_irq_unit
`default_nettype wire

/* File: hw/fsi_pkg.sv */
// Shared constants for the finger sensor interrupt unit
package fsi_pkg;
  // Register port geometry
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 8;
  localparam int unsigned NUM_SRC = 2;

  // Register offsets
  localparam logic [7:0] OFS_IRQ_CONTROL      = 8'h0D;
  localparam logic [7:0] OFS_IRQ_STATUS       = 8'h0E;
  localparam logic [7:0] OFS_FINGER_THRESHOLD = 8'h0F;

  // Reset values
  localparam logic [7:0] RST_IRQ_CONTROL      = 8'h00;
  localparam logic [7:0] RST_FINGER_THRESHOLD = 8'h00;
  localparam logic [1:0] RST_PENDING          = 2'h0;
  localparam logic [7:0] RST_RDATA            = 8'h00;
  // Unmapped reads return this value
  localparam logic [7:0] UNMAPPED_RDATA       = 8'h00;

  // Source indices
  localparam int unsigned SRC_FINGER = 0;
  localparam int unsigned SRC_EXT    = 1;

  // Control field positions (two bits each, bit0 finger, bit1 external)
  localparam int unsigned CTL_POL_LSB  = 6;
  localparam int unsigned CTL_TRIG_LSB = 4;
  localparam int unsigned CTL_MASK_LSB = 2;
  localparam int unsigned CTL_EN_LSB   = 0;

  // Status field positions
  localparam int unsigned STS_LIVE_LSB = 2;
  localparam int unsigned STS_PEND_LSB = 0;

  // Threshold field positions and widths
  localparam int unsigned THR_VOLT_LSB = 4;
  localparam int unsigned THR_VOLT_W   = 3;
  localparam int unsigned THR_CAP_LSB  = 0;
  localparam int unsigned THR_CAP_W    = 4;

  // Synchroniser depth for pin-level inputs
  localparam int unsigned SYNC_STAGES = 2;

  // Trigger type encoding of one control bit
  typedef enum logic {
    FSI_TRIG_EDGE  = 1'b0,
    FSI_TRIG_LEVEL = 1'b1
  } fsi_trig_t;
endpackage : fsi_pkg

/* File: hw/fsi_src_detect.sv */
// Per-source edge or level event detector with selectable polarity
`timescale 1ns/1ps
`default_nettype none
module fsi_src_detect
  import fsi_pkg::*;
(
  input  wire logic core_clk,
  input  wire logic nrst,
  input  wire logic level_in,
  input  wire logic polarity,
  input  wire logic trig_level,
  output logic      event_out
);
  logic active;
  logic active_q;
  logic active_d;

  // Polarity 1 means rising or high, 0 means falling or low
  assign active = polarity ? level_in : ~level_in;

  // Previous activity, reset as active so no edge fires before a real transition
  always_comb begin
    active_d = active;
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      active_q <= 1'b1;
    end else begin
      active_q <= active_d;
    end
  end

  // Level mode reports every cycle at the active level; edge mode only on entry
  assign event_out = (fsi_trig_t'(trig_level) == FSI_TRIG_LEVEL) ? active
                                                                 : (active & ~active_q);
endmodule : fsi_src_detect
`default_nettype wire

/* File: hw/fsi_sync.sv */
// Two-flop synchroniser for asynchronous level inputs
`timescale 1ns/1ps
`default_nettype none
module fsi_sync
  import fsi_pkg::*;
#(
  parameter int unsigned WIDTH = 2
) (
  input  wire logic             core_clk,
  input  wire logic             nrst,
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] meta_q;
  logic [WIDTH-1:0] stable_q;

  // Refuse a zero-width synchroniser at elaboration, not at run time
  if (WIDTH < 1) begin : g_bad_width
    $error("fsi_sync: WIDTH must be at least 1");
  end

  // First stage feeds only the second stage
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      meta_q   <= '0;
      stable_q <= '0;
    end else begin
      meta_q   <= async_in;
      stable_q <= meta_q;
    end
  end

  assign sync_out = stable_q;
endmodule : fsi_sync
`default_nettype wire

/* File: tb/fsi_host.sv */
// Host controller model driving the register port
`timescale 1ns/1ps
`default_nettype none
module fsi_host
  import fsi_pkg::*;
(
  input  wire logic       core_clk,
  output logic      [7:0] reg_addr,
  output logic            reg_wr,
  output logic            reg_rd,
  output logic      [7:0] reg_wdata,
  input  wire logic [7:0] reg_rdata
);
  // Idle bus at time zero
  initial begin
    reg_addr = 8'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_wdata = 8'h00;
  end
  // One-cycle write; data inverted after so a stale value never passes
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge core_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge core_clk);
    reg_wr <= 1'b0;
    reg_wdata <= ~d;
  endtask : wr
  // Read data taken one edge after the strobe was seen
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge core_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    @(posedge core_clk);
    d = reg_rdata;
  endtask : rd
  // Acknowledge writes ones to pending bits only
  task automatic ack(input logic [1:0] m);
    wr(OFS_IRQ_STATUS, {6'h00, m});
  endtask : ack
endmodule : fsi_host
`default_nettype wire

/* File: tb/fsi_irq_unit_chk.sv */
// Port-level checker for the finger sensor interrupt unit
`timescale 1ns/1ps
`default_nettype none
module fsi_irq_unit_chk
  import fsi_pkg::*;
(
  input wire logic       core_clk,
  input wire logic       nrst,
  input wire logic [7:0] reg_addr,
  input wire logic       reg_wr,
  input wire logic       reg_rd,
  input wire logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata,
  input wire logic       ext_irq_pin,
  input wire logic       finger_detect_raw,
  input wire logic       irq_out_pin,
  input wire logic       usb_ep2_req,
  input wire logic [2:0] detect_voltage_level,
  input wire logic [3:0] sharing_cap_size
);
  logic [1:0] en_q;
  logic [1:0] en_d;
  // Mirror of the enable bits, to judge the notification outputs
  always_comb begin
    en_d = en_q;
    if (reg_wr && reg_addr == OFS_IRQ_CONTROL) en_d = reg_wdata[1:0];
  end
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) en_q <= 2'h0;
    else en_q <= en_d;
  end
  default clocking @(posedge core_clk); endclocking
  default disable iff (!nrst);
  a_thr_fields: assert property (reg_wr && reg_addr == OFS_FINGER_THRESHOLD |=>
    ((({1'b0, detect_voltage_level, sharing_cap_size} ^ $past(reg_wdata)) & 8'h7F) == 8'h00))
    else $error("threshold outputs differ from written value");
  a_thr_hold: assert property (!(reg_wr && reg_addr == OFS_FINGER_THRESHOLD) |=>
    $stable(detect_voltage_level) && $stable(sharing_cap_size))
    else $error("threshold outputs moved without a write");
  a_ctl_rdback: assert property (reg_wr && reg_addr == OFS_IRQ_CONTROL ##2
    reg_rd && reg_addr == OFS_IRQ_CONTROL |=> reg_rdata == $past(reg_wdata, 3))
    else $error("control readback wrong");
  a_sts_rsvd: assert property (reg_rd && reg_addr == OFS_IRQ_STATUS |=>
    reg_rdata[7:4] == 4'h0) else $error("status reserved bits not zero");
  a_live_ext: assert property ($stable(ext_irq_pin) [*4] ##0
    (reg_rd && reg_addr == OFS_IRQ_STATUS) |=> reg_rdata[3] == $past(ext_irq_pin))
    else $error("live pin bit wrong");
  a_live_fin: assert property ($stable(finger_detect_raw) [*4] ##0
    (reg_rd && reg_addr == OFS_IRQ_STATUS) |=> reg_rdata[2] == $past(finger_detect_raw))
    else $error("live finger bit wrong");
  a_dis_quiet: assert property (en_q == 2'h0 |=> !irq_out_pin && !usb_ep2_req)
    else $error("notification while all sources disabled");
  a_ep2_irq: assert property (usb_ep2_req |-> irq_out_pin)
    else $error("endpoint pulse without interrupt pin");
  a_unmapped: assert property (reg_rd && (reg_addr < OFS_IRQ_CONTROL ||
    reg_addr > OFS_FINGER_THRESHOLD) |=> reg_rdata == UNMAPPED_RDATA)
    else $error("unmapped read not zero");
endmodule : fsi_irq_unit_chk
bind fsi_irq_unit fsi_irq_unit_chk chk (.core_clk, .nrst, .reg_addr, .reg_wr, .reg_rd,
  .reg_wdata, .reg_rdata, .ext_irq_pin, .finger_detect_raw, .irq_out_pin, .usb_ep2_req,
  .detect_voltage_level, .sharing_cap_size);
`default_nettype wire

/* File: tb/tb_fsi_irq_unit.sv */
// Testbench for the finger sensor interrupt unit
`timescale 1ns/1ps
`default_nettype none
module tb_fsi_irq_unit;
  import fsi_pkg::*;
  typedef struct {logic [7:0] ctl; logic e0, e1, f1; logic [7:0] sts; logic irq;} fsi_row_t;
  logic       core_clk, nrst, reg_wr, reg_rd, irq_out_pin, usb_ep2_req;
  logic       ext_irq_pin, finger_detect_raw, auto_finger_detect_enable;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, rv;
  logic [2:0] detect_voltage_level;
  logic [3:0] sharing_cap_size;
  int         error_cnt = 0;
  int         check_count = 0;
  int         ep2_cnt = 0;
  int         ep2_base = 0;
  // Control, pin before and after, finger after, status and pin expected
  fsi_row_t rows [8] = '{
    '{8'h02, 1'b1, 1'b0, 1'b0, 8'h02, 1'b1},
    '{8'h82, 1'b0, 1'b1, 1'b0, 8'h0A, 1'b1},
    '{8'h00, 1'b1, 1'b0, 1'b0, 8'h02, 1'b0},
    '{8'h0A, 1'b1, 1'b0, 1'b0, 8'h00, 1'b0},
    '{8'h41, 1'b1, 1'b1, 1'b1, 8'h0D, 1'b1},
    '{8'h01, 1'b1, 1'b1, 1'b1, 8'h0C, 1'b0},
    '{8'h51, 1'b1, 1'b1, 1'b1, 8'h0D, 1'b1},
    '{8'h22, 1'b1, 1'b0, 1'b0, 8'h02, 1'b1}};
  fsi_host host (.core_clk, .reg_addr, .reg_wr, .reg_rd, .reg_wdata, .reg_rdata);
  fsi_irq_unit dut (.core_clk, .nrst, .reg_addr, .reg_wr, .reg_rd, .reg_wdata, .reg_rdata,
    .ext_irq_pin, .finger_detect_raw, .auto_finger_detect_enable, .irq_out_pin,
    .usb_ep2_req, .detect_voltage_level, .sharing_cap_size);
  // Count endpoint request pulses; each stands for one cycle
  always @(posedge core_clk) begin
    if (usb_ep2_req === 1'b1) ep2_cnt <= ep2_cnt + 1;
  end
  task automatic idle(input int n);
    repeat (n) @(posedge core_clk);
  endtask : idle
  task automatic chk8(input string n, input logic [7:0] e, input logic [7:0] g);
    check_count++;
    if (g !== e) begin
      error_cnt++;
      $display("[FAIL] %s expected %h seen %h", n, e, g);
    end
  endtask : chk8
  task automatic sts(input logic [7:0] e);
    host.rd(OFS_IRQ_STATUS, rv);
    chk8("status", e, rv);
  endtask : sts
  task automatic stop_test;
    $display("checks %0d mismatches %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : stop_test
  // 25 ns clock
  initial begin
    core_clk = 1'b0;
    forever #12.5 core_clk = ~core_clk;
  end
  // Whole run is a few hundred cycles; cut a hang well past that
  initial begin
    #50us;
    error_cnt++;
    stop_test();
  end
  initial begin
    nrst = 1'b0;
    ext_irq_pin = 1'b1;
    finger_detect_raw = 1'b0;
    auto_finger_detect_enable = 1'b1;
    idle(2);
    nrst <= 1'b1;
    idle(4);
    host.rd(OFS_IRQ_CONTROL, rv);
    chk8("control", 8'h00, rv);
    host.rd(OFS_FINGER_THRESHOLD, rv);
    chk8("threshold", 8'h00, rv);
    host.rd(OFS_IRQ_STATUS, rv);
    chk8("status", 8'h08, rv & 8'hFC);
    $display("reset test done");
    // Settle with old pins, clear stale pending, then move the pins
    foreach (rows[i]) begin
      ext_irq_pin <= rows[i].e0;
      finger_detect_raw <= 1'b0;
      host.wr(OFS_IRQ_CONTROL, rows[i].ctl);
      idle(6);
      host.ack(2'h3);
      idle(2);
      ext_irq_pin <= rows[i].e1;
      finger_detect_raw <= rows[i].f1;
      idle(6);
      sts(rows[i].sts);
      chk8("irq", {7'h00, rows[i].irq}, {7'h00, irq_out_pin});
      $display("row %0d test done", i);
    end
    // Level source still active re-arms after acknowledge
    host.ack(2'h2);
    idle(4);
    sts(8'h02);
    // Mask write keeps pending; disabled keeps pin low
    host.wr(OFS_IRQ_CONTROL, 8'h08);
    idle(2);
    sts(8'h02);
    chk8("irq", 8'h00, {7'h00, irq_out_pin});
    host.ack(2'h2);
    host.wr(OFS_IRQ_CONTROL, 8'h02);
    ext_irq_pin <= 1'b1;
    idle(4);
    ep2_base = ep2_cnt;
    ext_irq_pin <= 1'b0;
    idle(6);
    chk8("irq", 8'h01, {7'h00, irq_out_pin});
    chk8("ep2", 8'h01, 8'(ep2_cnt - ep2_base));
    host.ack(2'h2);
    idle(2);
    chk8("irq", 8'h00, {7'h00, irq_out_pin});
    $display("ack test done");
    // Finger ignored while automatic detection is off
    auto_finger_detect_enable <= 1'b0;
    host.wr(OFS_IRQ_CONTROL, 8'h41);
    idle(4);
    host.ack(2'h3);
    finger_detect_raw <= 1'b1;
    idle(6);
    sts(8'h04);
    host.wr(OFS_IRQ_STATUS, 8'hF0);
    sts(8'h04);
    host.wr(OFS_FINGER_THRESHOLD, 8'hA5);
    idle(1);
    chk8("volt", 8'h02, {5'h00, detect_voltage_level});
    chk8("cap", 8'h05, {4'h0, sharing_cap_size});
    host.rd(OFS_FINGER_THRESHOLD, rv);
    chk8("threshold", 8'hA5, rv);
    host.wr(OFS_IRQ_CONTROL, 8'h5A);
    host.rd(OFS_IRQ_CONTROL, rv);
    chk8("control", 8'h5A, rv);
    host.rd(8'h30, rv);
    chk8("unmapped", UNMAPPED_RDATA, rv);
    $display("register test done");
    stop_test();
  end
endmodule : tb_fsi_irq_unit
`default_nettype wire
